// >>> dv/tb_top.sv
// self-checking bench for the ten-bit timer register slave and output pin
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_top;
    // ======================================================
    // signals, clock and design
    typedef struct {logic w; logic [4:0] a; logic [31:0] d; logic [31:0] e;} tbtmc_row_s;
    logic        ref_clk_i = 1'b0;
    logic        rst_n_i   = 1'b0;
    logic [4:0]  av_a      = 5'h00;
    logic        av_r      = 1'b0;
    logic        av_w      = 1'b0;
    logic [31:0] av_d      = 32'h0000_0000;
    logic        cap       = 1'b0;
    logic [31:0] rd_o, q;
    logic        wait_o, pin;
    int          n_mismatch = 0;
    int          n_checks   = 0;
    tbtmc_row_s  rows[8];
    initial forever #10 ref_clk_i = ~ref_clk_i;
    tbtmc_timer u_dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .avs_address_i(av_a),
        .avs_read_i(av_r), .avs_write_i(av_w), .avs_writedata_i(av_d),
        .avs_byteenable_i(4'hF), .avs_readdata_o(rd_o), .avs_waitrequest_o(wait_o),
        .capture_input_pin_i(cap), .timer_output_pin_o(pin));
    // ======================================================
    // one avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        av_a <= a; av_w <= w; av_r <= !w; av_d <= d;
        do @(posedge ref_clk_i); while (wait_o !== 1'b0);
        q = rd_o;
        av_w <= 1'b0;
        av_r <= 1'b0;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog sized well above the roughly sixteen hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge ref_clk_i);
        n_mismatch++;
        finish_test();
    end
    // ======================================================
    // main sequence
    initial begin
        rows = '{'{0, tbtmc_pkg::OFS_CTRL1, 0, 0}, '{0, tbtmc_pkg::OFS_CNTL, 0, 0},
                 '{0, 5'h1C, 0, 0}, '{1, tbtmc_pkg::OFS_CTRL1, 32'h0000_00E7, 0},
                 '{0, tbtmc_pkg::OFS_CTRL1, 0, 32'h0000_00E7},
                 '{1, tbtmc_pkg::OFS_CNTL, 32'h0000_00FF, 0},
                 '{0, tbtmc_pkg::OFS_CNTL, 0, 0}, '{1, tbtmc_pkg::OFS_CTRL1, 0, 0}};
        repeat (3) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        `CHK("pin_reset", 1'b0, pin)
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            if (!rows[i].w) `CHK("row_read", rows[i].e, q)
        end
        // compare mode, drive high on duty match, initial low
        bus(1, tbtmc_pkg::OFS_CTRL1, 32'h0000_0020);
        bus(1, tbtmc_pkg::OFS_DUTY, 32'h0000_0005);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0008);
        repeat (3) @(posedge ref_clk_i);
        `CHK("pin_initial", 1'b0, pin)
        repeat (10) @(posedge ref_clk_i);
        `CHK("pin_matched", 1'b1, pin)
        bus(0, tbtmc_pkg::OFS_FLAGS, 0);
        `CHK("flag_a", 1'b1, q[tbtmc_pkg::FLAG_A])
        // restart must bring the pin back to its initial level
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0008);
        repeat (2) @(posedge ref_clk_i);
        `CHK("pin_restart", 1'b0, pin)
        // initial high plus invert: requested high equals initial, pin stays low;
        // run past 1023 so the zero period value must raise the period flag on overflow
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL1, 32'h0000_002C);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0008);
        repeat (1040) @(posedge ref_clk_i);
        `CHK("pin_equal_inv", 1'b0, pin)
        bus(0, tbtmc_pkg::OFS_FLAGS, 0);
        `CHK("flag_ovf", 1'b1, q[tbtmc_pkg::FLAG_P])
        // period value 1 clears the counter every 128 clocks
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL1, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0009);
        bus(1, tbtmc_pkg::OFS_FLAGS, 32'h0000_0007);
        repeat (300) @(posedge ref_clk_i);
        bus(0, tbtmc_pkg::OFS_FLAGS, 0);
        `CHK("flag_p", 1'b1, q[tbtmc_pkg::FLAG_P])
        bus(0, tbtmc_pkg::OFS_CNTH, 0);
        `CHK("cnt_high", 32'h0000_0000, q)
        bus(0, tbtmc_pkg::OFS_CNTL, 0);
        `CHK("cnt_low_b7", 1'b0, q[7])
        // capture on rising edge of the capture input
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL1, 32'h0000_0040);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0008);
        bus(1, tbtmc_pkg::OFS_FLAGS, 32'h0000_0007);
        cap <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        bus(0, tbtmc_pkg::OFS_FLAGS, 0);
        `CHK("flag_cap", 1'b1, q[tbtmc_pkg::FLAG_C])
        // edge lands two counts after the timer-on restart
        bus(0, tbtmc_pkg::OFS_CAPT, 0);
        `CHK("cap_value", 32'h0000_0002, q)
        // pwm active high, period 128, duty 5; clear select set but must be ignored
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0000);
        bus(1, tbtmc_pkg::OFS_CTRL1, 32'h0000_00A9);
        bus(1, tbtmc_pkg::OFS_CTRL0, 32'h0000_0009);
        repeat (3) @(posedge ref_clk_i);
        `CHK("pwm_active", 1'b1, pin)
        repeat (10) @(posedge ref_clk_i);
        `CHK("pwm_idle", 1'b0, pin)
        repeat (118) @(posedge ref_clk_i);
        `CHK("pwm_period", 1'b1, pin)
        // reset in mid-run: pin, control and read buffer return to zero
        rst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        `CHK("pin_rst_mid", 1'b0, pin)
        rst_n_i <= 1'b1;
        bus(0, tbtmc_pkg::OFS_CTRL1, 0);
        `CHK("ctrl1_rst_mid", 32'h0000_0000, q)
        bus(0, tbtmc_pkg::OFS_CNTL, 0);
        `CHK("cnt_low_rst_mid", 32'h0000_0000, q)
        finish_test();
    end
endmodule // tb_top
`default_nettype wire

// >>> hw/tbtmc_cmp_if.sv
// counter and compare values passed between the timer and its comparators
`timescale 1ns/100ps
`default_nettype none
interface tbtmc_cmp_if;
    logic [tbtmc_pkg::CNT_W-1:0]  cnt;
    logic [tbtmc_pkg::PER_W-1:0]  per;
    logic [tbtmc_pkg::CNT_W-1:0]  duty;
    logic                         swap;
    logic                         p_match;
    logic                         a_match;
    logic                         duty_active;
    logic [tbtmc_pkg::SPAN_W-1:0] per_span;
    // ======================================================
    // timer drives values, comparator answers
    modport timer (output cnt, output per, output duty, output swap,
                   input p_match, input a_match, input duty_active, input per_span);
    modport cmp   (input cnt, input per, input duty, input swap,
                   output p_match, output a_match, output duty_active, output per_span);
endinterface : tbtmc_cmp_if
`default_nettype wire

// >>> hw/tbtmc_compare.sv
// period and duty comparators of the ten-bit timer
`timescale 1ns/100ps
`default_nettype none
module tbtmc_compare (
    // comparator side of the compare carrier
    tbtmc_cmp_if.cmp cif
);
    logic [tbtmc_pkg::PER_W-1:0]  per_m1;
    logic [tbtmc_pkg::SPAN_W-1:0] duty_len;

    // ======================================================
    // period comparator: top three bits against period minus one, low seven bits all ones, so matches fall on 128-clock steps
    assign per_m1       = cif.per - tbtmc_pkg::PER_ONE;   // 000 wraps to 111: full span
    assign cif.p_match  = (cif.cnt[tbtmc_pkg::CNT_W-1:tbtmc_pkg::LOW_W] == per_m1)
                       && (cif.cnt[tbtmc_pkg::LOW_W-1:0] == tbtmc_pkg::LOW_ONES);
    assign cif.per_span = (cif.per == tbtmc_pkg::PER_RST) ? tbtmc_pkg::SPAN_FULL
                        : {1'b0, cif.per, {tbtmc_pkg::LOW_W{1'b0}}};

    // ======================================================
    // duty comparator: a zero value never matches, the counter overflows instead
    assign cif.a_match  = (cif.cnt == cif.duty) && (cif.duty != tbtmc_pkg::CNT_ZERO);

    // ======================================================
    // pwm active window; a duty at or beyond the period gives a full-on output
    assign duty_len        = cif.swap ? cif.per_span : {1'b0, cif.duty};
    assign cif.duty_active = {1'b0, cif.cnt} < duty_len;
endmodule : tbtmc_compare
`default_nettype wire

// >>> hw/tbtmc_pkg.sv
// constants, register map and field layout of the ten-bit timer block
// Operation
// - 3-bit period value compared with count[9:7]
// - period match every 128*value clocks, 000=1024
// - clear select low: period match clears counter
// - period value zero: counter clears on overflow
// - mode field: compare, capture, pwm/pulse, timer
// - timer mode leaves output pin level undefined
// - compare mode: none, low, high, toggle on match
// - pwm mode: inactive, active, pwm, single pulse
// - capture: rising, falling, both edges, disabled
// - requested level equal initial: pin unchanged
// - timer on rising returns pin to initial level
// - compare mode initial level from control bit
// - control bit: pwm active level, pulse start level
// - invert bit inverts pin, not in timer mode
// - swap bit exchanges period and duty sources; the code swaps them in pwm mode only
// - clear select high: duty match clears counter
// - clear select ignored in pwm, pulse, capture
// - read-only low byte of counter, reset zero
// - timer on rise clears counter, fall freezes it
// - high byte read latches low byte into buffer
package tbtmc_pkg;
    // ======================================================
    // widths
    localparam int unsigned CNT_W  = 10;
    localparam int unsigned PER_W  = 3;
    localparam int unsigned LOW_W  = 7;
    localparam int unsigned REG_W  = 8;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned FLAG_W = 3;
    localparam int unsigned SPAN_W = 11;
    typedef logic [DATA_W-1:0] tbtmc_word_t;
    // ======================================================
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL0 = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL1 = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CNTL  = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CNTH  = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_DUTY  = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_FLAGS = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_CAPT  = 5'h18;
    // ======================================================
    // field positions
    localparam int unsigned F_ON      = 3;
    localparam int unsigned F_PER_HI  = 2;
    localparam int unsigned F_PER_LO  = 0;
    localparam int unsigned F_MODE_HI = 7;
    localparam int unsigned F_MODE_LO = 6;
    localparam int unsigned F_FUNC_HI = 5;
    localparam int unsigned F_FUNC_LO = 4;
    localparam int unsigned F_INIT    = 3;
    localparam int unsigned F_INV     = 2;
    localparam int unsigned F_SWAP    = 1;
    localparam int unsigned F_CLR     = 0;
    localparam int unsigned FLAG_A    = 0;
    localparam int unsigned FLAG_P    = 1;
    localparam int unsigned FLAG_C    = 2;
    // ======================================================
    // reset values and fixed patterns
    localparam logic [REG_W-1:0]  CTRL1_RST = 8'h00;
    localparam logic [PER_W-1:0]  PER_RST   = 3'h0;
    localparam logic [PER_W-1:0]  PER_ONE   = 3'h1;
    localparam logic [CNT_W-1:0]  CNT_ZERO  = 10'h000;
    localparam logic [CNT_W-1:0]  CNT_ONE   = 10'h001;
    localparam logic [CNT_W-1:0]  CNT_MAX   = 10'h3FF;
    localparam logic [LOW_W-1:0]  LOW_ONES  = 7'h7F;
    localparam logic [SPAN_W-1:0] SPAN_FULL = 11'h400;
    localparam logic [SPAN_W-1:0] SPAN_ONE  = 11'h001;
    localparam logic [REG_W-1:0]  BYTE_ZERO = 8'h00;
    localparam logic [FLAG_W-1:0] FLAG_NONE = 3'h0;
    localparam tbtmc_word_t       WORD_ZERO = 32'h0000_0000;
    // ======================================================
    // operating modes, output function codes and capture edge codes
    localparam logic [1:0] MODE_CMP  = 2'h0;
    localparam logic [1:0] MODE_CAP  = 2'h1;
    localparam logic [1:0] MODE_PWM  = 2'h2;
    localparam logic [1:0] MODE_TMR  = 2'h3;
    localparam logic [1:0] FN_NONE   = 2'h0;
    localparam logic [1:0] FN_LOW    = 2'h1;
    localparam logic [1:0] FN_HIGH   = 2'h2;
    localparam logic [1:0] FN_TOGGLE = 2'h3;
    localparam logic [1:0] FN_INACT  = 2'h0;
    localparam logic [1:0] FN_ACT    = 2'h1;
    localparam logic [1:0] FN_PWM    = 2'h2;
    localparam logic [1:0] FN_PULSE  = 2'h3;
    localparam logic [1:0] FN_RISE   = 2'h0;
    localparam logic [1:0] FN_FALL   = 2'h1;
    localparam logic [1:0] FN_BOTH   = 2'h2;
endpackage : tbtmc_pkg

// >>> hw/tbtmc_timer.sv
// ten-bit timer: register slave, counter, output pin and capture logic
`timescale 1ns/100ps
`default_nettype none
module tbtmc_timer (
    // clock and reset
    input  wire logic                           ref_clk_i,
    input  wire logic                           rst_n_i,
    // avalon-mm register slave
    input  wire logic [tbtmc_pkg::ADDR_W-1:0]   avs_address_i,
    input  wire logic                           avs_read_i,
    input  wire logic                           avs_write_i,
    input  wire logic [tbtmc_pkg::DATA_W-1:0]   avs_writedata_i,
    input  wire logic [3:0]                     avs_byteenable_i,
    output logic      [tbtmc_pkg::DATA_W-1:0]   avs_readdata_o,
    output logic                                avs_waitrequest_o,
    // timer pins
    input  wire logic                           capture_input_pin_i,
    output logic                                timer_output_pin_o
);
    // ======================================================
    // declarations
    logic                          wait_q, wait_d;
    logic [tbtmc_pkg::DATA_W-1:0]  rdata_q, rdata_d, rd_mux;
    logic                          on_q, on_d, on_prev_q;
    logic [tbtmc_pkg::PER_W-1:0]   per_q, per_d;
    logic [tbtmc_pkg::REG_W-1:0]   ctrl1_q, ctrl1_d;
    logic [tbtmc_pkg::CNT_W-1:0]   duty_q, duty_d;
    logic [tbtmc_pkg::CNT_W-1:0]   cnt_q, cnt_d;
    logic [tbtmc_pkg::REG_W-1:0]   buf_q, buf_d;
    logic [tbtmc_pkg::FLAG_W-1:0]  flags_q, flags_d, flag_set, flag_clr;
    logic [tbtmc_pkg::CNT_W-1:0]   cap_q, cap_d;
    logic                          cap_prev_q;
    logic                          lvl_q, lvl_d, pulse_q, pulse_d, pin_q, pin_d;
    logic                          req, rd_acc, wr_acc;
    logic                          wr_ctrl0, wr_ctrl1, wr_duty_lo, wr_duty_hi, wr_flags;
    logic                          rd_cnth;
    logic [1:0]                    mode, func;
    logic                          init_lvl, inv, swap, clr_sel;
    logic                          is_cmp, is_cap, is_pwm, is_tmr, cmp_like;
    logic                          on_rise, clear_on_a, cnt_clear, duty_end;
    logic                          set_a, set_p, set_c, cap_edge;
    logic                          req_lvl, cmp_change, cmp_next, pwm_lvl;

    tbtmc_cmp_if cif ();

    // address decode shared by the read mux and the write strobes
    function automatic logic hit(input logic [tbtmc_pkg::ADDR_W-1:0] a,
                                 input logic [tbtmc_pkg::ADDR_W-1:0] ofs);
        return a == ofs;
    endfunction

    // ======================================================
    // comparators
    tbtmc_compare u_compare (
        .cif (cif.cmp)
    );
    assign cif.cnt  = cnt_q;
    assign cif.per  = per_q;
    assign cif.duty = duty_q;
    assign cif.swap = swap;

    // ======================================================
    // bus handshake: one wait cycle, then accept; data is ready before the accept edge
    assign req    = avs_read_i | avs_write_i;
    assign rd_acc = avs_read_i & ~wait_q;
    assign wr_acc = avs_write_i & ~wait_q;
    assign wait_d = ~(req & wait_q);

    // write strobes; unmapped offsets and missing byte lanes are ignored
    assign wr_ctrl0   = wr_acc & hit(avs_address_i, tbtmc_pkg::OFS_CTRL0) & avs_byteenable_i[0];
    assign wr_ctrl1   = wr_acc & hit(avs_address_i, tbtmc_pkg::OFS_CTRL1) & avs_byteenable_i[0];
    assign wr_duty_lo = wr_acc & hit(avs_address_i, tbtmc_pkg::OFS_DUTY) & avs_byteenable_i[0];
    assign wr_duty_hi = wr_acc & hit(avs_address_i, tbtmc_pkg::OFS_DUTY) & avs_byteenable_i[1];
    assign wr_flags   = wr_acc & hit(avs_address_i, tbtmc_pkg::OFS_FLAGS) & avs_byteenable_i[0];
    assign rd_cnth    = rd_acc & hit(avs_address_i, tbtmc_pkg::OFS_CNTH);

    // register next values
    assign on_d    = wr_ctrl0 ? avs_writedata_i[tbtmc_pkg::F_ON] : on_q;
    assign per_d   = wr_ctrl0 ? avs_writedata_i[tbtmc_pkg::F_PER_HI:tbtmc_pkg::F_PER_LO] : per_q;
    assign ctrl1_d = wr_ctrl1 ? avs_writedata_i[tbtmc_pkg::REG_W-1:0] : ctrl1_q;
    assign duty_d  = {wr_duty_hi ? avs_writedata_i[tbtmc_pkg::CNT_W-1:tbtmc_pkg::REG_W]
                                 : duty_q[tbtmc_pkg::CNT_W-1:tbtmc_pkg::REG_W],
                      wr_duty_lo ? avs_writedata_i[tbtmc_pkg::REG_W-1:0]
                                 : duty_q[tbtmc_pkg::REG_W-1:0]};

    // low byte is only ever read through the buffer, latched at the accept edge one clock after the high byte is sampled
    assign buf_d = rd_cnth ? cnt_q[tbtmc_pkg::REG_W-1:0] : buf_q;

    // ======================================================
    // read mux; unmapped offsets read zero
    assign rd_mux =
        hit(avs_address_i, tbtmc_pkg::OFS_CTRL0) ?
            tbtmc_pkg::tbtmc_word_t'({on_q, per_q}) :
        hit(avs_address_i, tbtmc_pkg::OFS_CTRL1) ?
            tbtmc_pkg::tbtmc_word_t'(ctrl1_q) :
        hit(avs_address_i, tbtmc_pkg::OFS_CNTL) ?
            tbtmc_pkg::tbtmc_word_t'(buf_q) :
        hit(avs_address_i, tbtmc_pkg::OFS_CNTH) ?
            tbtmc_pkg::tbtmc_word_t'(cnt_q[tbtmc_pkg::CNT_W-1:tbtmc_pkg::REG_W]) :
        hit(avs_address_i, tbtmc_pkg::OFS_DUTY) ?
            tbtmc_pkg::tbtmc_word_t'(duty_q) :
        hit(avs_address_i, tbtmc_pkg::OFS_FLAGS) ?
            tbtmc_pkg::tbtmc_word_t'(flags_q) :
        hit(avs_address_i, tbtmc_pkg::OFS_CAPT) ?
            tbtmc_pkg::tbtmc_word_t'(cap_q) :
            tbtmc_pkg::WORD_ZERO;
    assign rdata_d = (avs_read_i & wait_q) ? rd_mux : rdata_q;

    // ======================================================
    // control field decode
    assign mode     = ctrl1_q[tbtmc_pkg::F_MODE_HI:tbtmc_pkg::F_MODE_LO];
    assign func     = ctrl1_q[tbtmc_pkg::F_FUNC_HI:tbtmc_pkg::F_FUNC_LO];
    assign init_lvl = ctrl1_q[tbtmc_pkg::F_INIT];
    assign inv      = ctrl1_q[tbtmc_pkg::F_INV];
    assign swap     = ctrl1_q[tbtmc_pkg::F_SWAP];
    assign clr_sel  = ctrl1_q[tbtmc_pkg::F_CLR];
    assign is_cmp   = (mode == tbtmc_pkg::MODE_CMP);
    assign is_cap   = (mode == tbtmc_pkg::MODE_CAP);
    assign is_pwm   = (mode == tbtmc_pkg::MODE_PWM);
    assign is_tmr   = (mode == tbtmc_pkg::MODE_TMR);
    assign cmp_like = is_cmp | is_tmr;

    // ======================================================
    // counter clear source; the select bit only counts in compare and timer modes
    assign on_rise    = on_q & ~on_prev_q;
    assign clear_on_a = cmp_like & clr_sel;
    assign cnt_clear  = (clear_on_a | (is_pwm & swap)) ? cif.a_match
                      : cif.p_match;
    assign cnt_d = on_rise ? tbtmc_pkg::CNT_ZERO
                 : !on_q ? cnt_q
                 : cnt_clear ? tbtmc_pkg::CNT_ZERO
                 : cnt_q + tbtmc_pkg::CNT_ONE;

    // ======================================================
    // event flags: hardware set wins over a same-cycle write-one clear
    assign set_a    = on_q & cif.a_match & ~is_cap;
    assign set_p    = on_q & cif.p_match & ~clear_on_a;
    assign cap_edge = (func == tbtmc_pkg::FN_RISE) ? (capture_input_pin_i & ~cap_prev_q)
                    : (func == tbtmc_pkg::FN_FALL) ? (~capture_input_pin_i & cap_prev_q)
                    : (func == tbtmc_pkg::FN_BOTH) ? (capture_input_pin_i ^ cap_prev_q)
                    : 1'b0;
    assign set_c    = on_q & is_cap & cap_edge;
    assign flag_set = {set_c, set_p, set_a};
    assign flag_clr = wr_flags ? avs_writedata_i[tbtmc_pkg::FLAG_W-1:0] : tbtmc_pkg::FLAG_NONE;
    assign flags_d  = (flags_q & ~flag_clr) | flag_set;
    assign cap_d    = set_c ? cnt_q : cap_q;

    // ======================================================
    // compare mode pin action on a duty match
    assign req_lvl    = (func == tbtmc_pkg::FN_HIGH);
    assign cmp_next   = (func == tbtmc_pkg::FN_TOGGLE) ? ~lvl_q : req_lvl;
    assign cmp_change = on_q & cif.a_match & (func != tbtmc_pkg::FN_NONE)
                      & ((func == tbtmc_pkg::FN_TOGGLE) | (req_lvl != init_lvl));

    // pwm and single pulse level; the control bit is the active level
    assign duty_end = swap ? cif.p_match : cif.a_match;
    assign pulse_d  = on_rise | (pulse_q & ~(on_q & duty_end));
    assign pwm_lvl  = (func == tbtmc_pkg::FN_INACT) ? ~init_lvl
                    : (func == tbtmc_pkg::FN_ACT)   ? init_lvl
                    : (func == tbtmc_pkg::FN_PWM)   ? (cif.duty_active ? init_lvl : ~init_lvl)
                    : (pulse_d ? init_lvl : ~init_lvl);

    // level before inversion; a timer-on rise restarts from the initial level
    assign lvl_d = on_rise ? init_lvl
                 : (is_pwm & on_q) ? pwm_lvl
                 : (is_cmp & cmp_change) ? cmp_next
                 : lvl_q;
    // the pin is unused in timer mode, so it is simply held low there
    assign pin_d = is_tmr ? 1'b0 : (lvl_d ^ inv);

    // ======================================================
    // bus registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wait_q  <= 1'b1;
            rdata_q <= tbtmc_pkg::WORD_ZERO;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // software-visible control registers
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_q    <= 1'b0;
            per_q   <= tbtmc_pkg::PER_RST;
            ctrl1_q <= tbtmc_pkg::CTRL1_RST;
            duty_q  <= tbtmc_pkg::CNT_ZERO;
        end else begin
            on_q    <= on_d;
            per_q   <= per_d;
            ctrl1_q <= ctrl1_d;
            duty_q  <= duty_d;
        end
    end

    // counter, read buffer, flags and capture
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_prev_q  <= 1'b0;
            cnt_q      <= tbtmc_pkg::CNT_ZERO;
            buf_q      <= tbtmc_pkg::BYTE_ZERO;
            flags_q    <= tbtmc_pkg::FLAG_NONE;
            cap_q      <= tbtmc_pkg::CNT_ZERO;
            cap_prev_q <= 1'b0;
        end else begin
            on_prev_q  <= on_q;
            cnt_q      <= cnt_d;
            buf_q      <= buf_d;
            flags_q    <= flags_d;
            cap_q      <= cap_d;
            cap_prev_q <= capture_input_pin_i;
        end
    end

    // output pin state
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q   <= 1'b0;
            pulse_q <= 1'b0;
            pin_q   <= 1'b0;
        end else begin
            lvl_q   <= lvl_d;
            pulse_q <= pulse_d;
            pin_q   <= pin_d;
        end
    end

    assign avs_readdata_o     = rdata_q;
    assign avs_waitrequest_o  = wait_q;
    assign timer_output_pin_o = pin_q;

    // ======================================================
    // assertions
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence bus_req_s;
        req && wait_q;
    endsequence
    sequence bus_done_s;
        !avs_waitrequest_o ##1 avs_waitrequest_o;
    endsequence
    bus_answer_a: assert property (bus_req_s |=> bus_done_s)
        else $error("bus request not answered after one wait cycle");

    on_clear_a: assert property (on_rise |=> cnt_q == tbtmc_pkg::CNT_ZERO)
        else $error("counter not cleared on timer on rise");
    freeze_a: assert property (!on_q |=> cnt_q == $past(cnt_q))
        else $error("counter moved while timer off");

    per_clear_a: assert property (on_q && !on_rise && cmp_like && !clr_sel && cif.p_match
                                  |=> cnt_q == tbtmc_pkg::CNT_ZERO)
        else $error("period match did not clear counter");
    ovf_wrap_a: assert property (on_q && !on_rise && cmp_like && !clr_sel
                                 && per_q == tbtmc_pkg::PER_RST && cnt_q == tbtmc_pkg::CNT_MAX
                                 |=> cnt_q == tbtmc_pkg::CNT_ZERO)
        else $error("counter did not clear on overflow");
    a_clear_a: assert property (on_q && !on_rise && clear_on_a && cif.a_match
                                |=> cnt_q == tbtmc_pkg::CNT_ZERO)
        else $error("duty match did not clear counter");
    pwm_noclr_a: assert property (on_q && !on_rise && is_pwm && !swap && clr_sel
                                  && cif.a_match && !cif.p_match
                                  |=> cnt_q == $past(cnt_q) + tbtmc_pkg::CNT_ONE)
        else $error("clear select acted in pwm mode");

    period_cmp_a: assert property (cif.p_match == ({1'b0, cnt_q} + tbtmc_pkg::SPAN_ONE
                                                   == cif.per_span))
        else $error("period match at wrong count");

    pin_init_a: assert property (on_rise && is_cmp |=> pin_q == $past(init_lvl ^ inv))
        else $error("pin not at initial level after timer on rise");
    cmp_keep_a: assert property (on_q && !on_rise && is_cmp && cif.a_match && !wr_acc
                                 && (func == tbtmc_pkg::FN_LOW || func == tbtmc_pkg::FN_HIGH)
                                 && req_lvl == init_lvl |=> pin_q == $past(pin_q))
        else $error("pin changed to a level equal to the initial level");
    cmp_toggle_a: assert property (on_q && !on_rise && is_cmp && cif.a_match && !wr_acc
                                   && func == tbtmc_pkg::FN_TOGGLE |=> pin_q != $past(pin_q))
        else $error("toggle action did not toggle the pin");
    pwm_force_a: assert property (on_q && is_pwm && func == tbtmc_pkg::FN_ACT
                                  |=> pin_q == $past(init_lvl ^ inv))
        else $error("forced active level wrong");

    low_buf_a: assert property (rd_cnth |=> buf_q == $past(cnt_q[tbtmc_pkg::REG_W-1:0]))
        else $error("high byte read did not latch low byte");
    flag_a_a: assert property (set_a |=> flags_q[tbtmc_pkg::FLAG_A])
        else $error("duty match flag not raised");
    flag_p_a: assert property (set_p |=> flags_q[tbtmc_pkg::FLAG_P])
        else $error("period match flag not raised");

    // capture: flag and count must both land at the edge after the pin edge
    cap_flag_a: assert property (set_c |=> flags_q[tbtmc_pkg::FLAG_C])
        else $error("capture flag not raised");
    cap_value_a: assert property (set_c |=> cap_q == $past(cnt_q))
        else $error("capture register missed the count");

    // timer mode: pin is parked low so a stale level never leaks out
    tmr_pin_a: assert property (is_tmr |=> pin_q == 1'b0)
        else $error("pin not held low in timer mode");
endmodule : tbtmc_timer
`default_nettype wire
